// *** hdl/tpc_pwm_top.sv ***
// module: three-phase centre-based pwm generator with shutdown, chopping and register port
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module tpc_pwm_top
   import tpc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [TPC_AW-1:0] addr,
   input wire logic [TPC_DW-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [TPC_DW-1:0] rdata,
   input wire logic trip_in_n,
   input wire logic current_sense_in,
   output logic phase_a_high_out,
   output logic phase_a_low_out,
   output logic phase_b_high_out,
   output logic phase_b_low_out,
   output logic phase_c_high_out,
   output logic phase_c_low_out,
   output logic period_sync_pulse,
   output logic sync_irq,
   output logic shutdown_irq
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // live registers written by software

   // R19 timing, duty and control words; period, min pulse, duties and mode are 16-bit, dead 10-bit, sync width 8-bit
   logic [15:0] half_period_count_q;
   logic [9:0] dead_time_count_q;
   logic [15:0] min_pulse_count_q;
   logic [7:0] sync_width_count_q;
   logic [2:0][15:0] duty_q;
   logic [8:0] output_segment_ctrl_q;
   logic [9:0] gate_chop_ctrl_q;
   logic [15:0] mode_control_reg_q;

   wire wr_period = wr_stb && (addr == TPC_REG_PERIOD);
   wire wr_dead = wr_stb && (addr == TPC_REG_DEAD);
   wire wr_minp = wr_stb && (addr == TPC_REG_MINPULSE);
   wire wr_syncw = wr_stb && (addr == TPC_REG_SYNCW);
   wire wr_duty_a = wr_stb && (addr == TPC_REG_DUTY_A);
   wire wr_duty_b = wr_stb && (addr == TPC_REG_DUTY_B);
   wire wr_duty_c = wr_stb && (addr == TPC_REG_DUTY_C);
   wire wr_seg = wr_stb && (addr == TPC_REG_SEG);
   wire wr_gate = wr_stb && (addr == TPC_REG_GATE);
   wire wr_mode = wr_stb && (addr == TPC_REG_MODE);
   wire wr_swtrip = wr_stb && (addr == TPC_REG_SWTRIP);
   wire wr_clr = wr_stb && (addr == TPC_REG_TRIPCLR) && wdata[TPC_CLR_BIT];

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         half_period_count_q <= TPC_PERIOD_RST;
         dead_time_count_q <= TPC_DEAD_RST;
         min_pulse_count_q <= TPC_MINPULSE_RST;
         // R25 sync width reset
         sync_width_count_q <= TPC_SYNCW_RST;
         duty_q <= {TPC_DUTY_RST, TPC_DUTY_RST, TPC_DUTY_RST};
         output_segment_ctrl_q <= TPC_SEG_RST;
         gate_chop_ctrl_q <= TPC_GATE_RST;
         mode_control_reg_q <= TPC_MODE_RST;
      end else begin
         if (wr_period) half_period_count_q <= wdata;
         if (wr_dead) dead_time_count_q <= wdata[9:0];
         if (wr_minp) min_pulse_count_q <= wdata;
         if (wr_syncw) sync_width_count_q <= wdata[7:0];
         if (wr_duty_a) duty_q[0] <= wdata;
         if (wr_duty_b) duty_q[1] <= wdata;
         if (wr_duty_c) duty_q[2] <= wdata;
         if (wr_seg) output_segment_ctrl_q <= wdata[8:0];
         if (wr_gate) gate_chop_ctrl_q <= wdata[9:0];
         if (wr_mode) mode_control_reg_q <= wdata;
      end
   end

   // R8 update mode bit
   wire double_mode = mode_control_reg_q[TPC_MODE_DOUBLE_BIT];

   ////////////////////////////////////////////////////////////////////////////////////////
   // shutdown controller

   logic trip_s1_q;
   logic trip_s2_q;
   logic oc_s1_q;
   logic oc_s2_q;
   logic shut_q;
   logic oc_flag_q;
   logic shutdown_irq_q;

   // R11 R13 unclocked kill: pin or comparator clears output flops at once
   wire out_kill_n = resetn && trip_in_n && !current_sense_in;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trip_s1_q <= 1'b1;
         trip_s2_q <= 1'b1;
         oc_s1_q <= 1'b0;
         oc_s2_q <= 1'b0;
      end else begin
         trip_s1_q <= trip_in_n;
         trip_s2_q <= trip_s1_q;
         oc_s1_q <= current_sense_in;
         oc_s2_q <= oc_s1_q;
      end
   end

   // R12 R14 R16 all sources merged into one latched shutdown
   wire shut_set = !trip_s2_q || oc_s2_q || wr_swtrip;
   // R27 release needs software clear with trip high and no over-current
   wire shut_clr = wr_clr && trip_s2_q && !oc_s2_q;
   // set wins over clear in the same cycle
   wire shut_d = shut_set ? 1'b1 : (shut_clr ? 1'b0 : shut_q);
   wire oc_flag_d = oc_s2_q ? 1'b1 : (wr_clr ? 1'b0 : oc_flag_q);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         shut_q <= 1'b0;
         oc_flag_q <= 1'b0;
         shutdown_irq_q <= 1'b0;
      end else begin
         shut_q <= shut_d;
         oc_flag_q <= oc_flag_d;
         // R18 shutdown interrupt on entry
         shutdown_irq_q <= shut_set && !shut_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // timing unit: up count in first half, down count in second half

   tpc_cfg_t cfg_q;
   logic [15:0] cnt_q;
   logic half_q;

   // R22 period counts one half; zero behaves as one
   wire [15:0] cnt_top = (cfg_q.period == 16'h0000) ? 16'h0000 : cfg_q.period - 16'h0001;
   wire period_start = !shut_q && half_q && (cnt_q == 16'h0000);
   wire period_mid = !shut_q && !half_q && (cnt_q >= cnt_top);
   // R6 R7 update instants
   wire load_cfg = period_start || (period_mid && double_mode);

   tpc_cfg_t cfg_live;
   assign cfg_live.period = half_period_count_q;
   assign cfg_live.dead = dead_time_count_q;
   assign cfg_live.min_pulse = min_pulse_count_q;
   assign cfg_live.sync_width = sync_width_count_q;
   assign cfg_live.duty = duty_q;
   assign cfg_live.xover = output_segment_ctrl_q[TPC_SEG_XOVER_LSB +: 3];
   assign cfg_live.out_en = output_segment_ctrl_q[TPC_SEG_EN_LSB +: 6];

   wire [15:0] cnt_up = cnt_q + 16'h0001;
   wire [15:0] cnt_dn = cnt_q - 16'h0001;
   // R16 shutdown parks the counter so a fresh period starts on release
   wire [15:0] cnt_d = shut_q ? 16'h0000 :
                       (!half_q ? ((cnt_q >= cnt_top) ? cnt_q : cnt_up) :
                       ((cnt_q == 16'h0000) ? cnt_q : cnt_dn));
   wire half_d = shut_q ? 1'b1 : (period_mid ? 1'b1 : (period_start ? 1'b0 : half_q));

   // R17 one count per clock cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 16'h0000;
         half_q <= 1'b1;
         cfg_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         half_q <= half_d;
         if (load_cfg) cfg_q <= cfg_live;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // sync pulse

   logic [7:0] sync_cnt_q;
   logic sync_q;
   logic sync_irq_q;

   // R25 stays high for width plus one cycles
   wire sync_hold = sync_q && (sync_cnt_q != 8'h00);
   wire [7:0] sync_cnt_d = load_cfg ? sync_width_count_q :
                           (sync_hold ? sync_cnt_q - 8'h01 : 8'h00);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_cnt_q <= 8'h00;
         sync_q <= 1'b0;
         sync_irq_q <= 1'b0;
      end else begin
         sync_cnt_q <= sync_cnt_d;
         // R9 R10 pulse at start and, in double mode, at midpoint
         sync_q <= load_cfg || sync_hold;
         // R18 sync interrupt
         sync_irq_q <= load_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // gate chopping clock: toggles every chop value plus one cycles

   logic [7:0] chop_cnt_q;
   logic chop_q;

   // R4 frequency straight from the 8-bit field
   wire chop_wrap = (chop_cnt_q >= gate_chop_ctrl_q[7:0]);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         chop_cnt_q <= 8'h00;
         chop_q <= 1'b0;
      end else begin
         chop_cnt_q <= chop_wrap ? 8'h00 : chop_cnt_q + 8'h01;
         if (chop_wrap) chop_q <= !chop_q;
      end
   end

   // R5 group enables, plain pass-through when off
   wire chop_hi = gate_chop_ctrl_q[TPC_GATE_HI_BIT] ? chop_q : 1'b1;
   wire chop_lo = gate_chop_ctrl_q[TPC_GATE_LO_BIT] ? chop_q : 1'b1;

   ////////////////////////////////////////////////////////////////////////////////////////
   // per-phase waveform, output control and gate mixing

   // R23 dead time is two cycles per count
   wire [17:0] dead_cyc = {7'h00, cfg_q.dead, 1'b0};
   wire [17:0] period_w = {2'b00, cfg_q.period};
   wire [17:0] cnt_w = {2'b00, cnt_q};
   wire [17:0] minp_w = {2'b00, cfg_q.min_pulse};

   logic [5:0] drive_q;

   genvar p;
   generate
      for (p = 0; p < TPC_PHASES; p = p + 1) begin : g_phase
         wire [17:0] duty_w = {2'b00, cfg_q.duty[p]};
         // centre instant where the high side switches, clamped at full duty
         wire [17:0] edge_w = (duty_w >= period_w) ? 18'h00000 : period_w - duty_w;
         // R20 complementary pair with dead time moving both edges apart
         wire hi_raw = (cnt_w >= edge_w + dead_cyc);
         wire lo_raw = (cnt_w + dead_cyc < edge_w);
         // R26 drop pulses narrower than twice the minimum setting in cycles
         wire hi_keep = (period_w - edge_w >= dead_cyc + minp_w);
         wire lo_keep = (edge_w >= dead_cyc + minp_w);
         wire hi_wave = hi_raw && hi_keep;
         wire lo_wave = lo_raw && lo_keep;
         // R3 crossover swaps the pair
         wire hi_sel = cfg_q.xover[p] ? lo_wave : hi_wave;
         wire lo_sel = cfg_q.xover[p] ? hi_wave : lo_wave;
         // R2 individual enables
         wire hi_en = hi_sel && cfg_q.out_en[2*p];
         wire lo_en = lo_sel && cfg_q.out_en[2*p+1];
         // R21 chopping mixed in after output control
         wire hi_d = hi_en && chop_hi && !shut_q;
         wire lo_d = lo_en && chop_lo && !shut_q;

         // R11 R13 out_kill_n clears these without waiting for a clock
         always_ff @(posedge sys_clk or negedge out_kill_n) begin
            if (!out_kill_n) begin
               drive_q[2*p] <= 1'b0;
               drive_q[2*p+1] <= 1'b0;
            end else begin
               drive_q[2*p] <= hi_d;
               drive_q[2*p+1] <= lo_d;
            end
         end
      end
   endgenerate

   // R1 three high-side and three low-side outputs
   assign phase_a_high_out = drive_q[0];
   assign phase_a_low_out = drive_q[1];
   assign phase_b_high_out = drive_q[2];
   assign phase_b_low_out = drive_q[3];
   assign phase_c_high_out = drive_q[4];
   assign phase_c_low_out = drive_q[5];
   assign period_sync_pulse = sync_q;
   assign sync_irq = sync_irq_q;
   assign shutdown_irq = shutdown_irq_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // read port: data stands one cycle after the strobe

   logic [15:0] rdata_q;

   // R15 R24 status: trip level, latched shutdown, over-current, half-period
   wire [15:0] status_word = {12'h000, half_q, oc_flag_q, shut_q, trip_s2_q};

   wire [15:0] rd_mux =
      (addr == TPC_REG_PERIOD) ? half_period_count_q :
      (addr == TPC_REG_DEAD) ? {6'h00, dead_time_count_q} :
      (addr == TPC_REG_MINPULSE) ? min_pulse_count_q :
      (addr == TPC_REG_SYNCW) ? {8'h00, sync_width_count_q} :
      (addr == TPC_REG_DUTY_A) ? duty_q[0] :
      (addr == TPC_REG_DUTY_B) ? duty_q[1] :
      (addr == TPC_REG_DUTY_C) ? duty_q[2] :
      (addr == TPC_REG_SEG) ? {7'h00, output_segment_ctrl_q} :
      (addr == TPC_REG_GATE) ? {6'h00, gate_chop_ctrl_q} :
      (addr == TPC_REG_MODE) ? mode_control_reg_q :
      (addr == TPC_REG_STATUS) ? status_word :
      16'h0000;

   // data is zero outside the read-back cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rd_stb ? rd_mux : 16'h0000;
      end
   end

   assign rdata = rdata_q;

endmodule // tpc_pwm_top

`default_nettype wire

// *** hdl/tpc_pkg.sv ***
// package: register map, field layout, reset values and shadow types of the three-phase pwm
////////////////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1 - three complementary active-high pairs: high-side and low-side output per phase
// R2 - each of the six outputs has its own enable bit in the segment register
// R3 - per-phase crossover bit swaps the high-side and low-side waveforms
// R4 - chopping signal frequency set directly by an 8-bit gate field
// R5 - chopping enabled separately for high-side group and low-side group
// R6 - single update mode latches new duty values once per switching period
// R7 - double update mode also latches new values at the period midpoint
// R8 - mode register bit 6 selects single or double update mode
// R9 - sync pulse at every period start, and at midpoint in double mode
// R10 - sync pulse duration comes from the sync-width register
// R11 - trip input low forces all six outputs off without a clock edge
// R12 - over-current report from the current-sense comparator shuts outputs down
// R13 - pin and over-current shutdown paths act without clocked logic
// R14 - a write to the software-trip register shuts outputs down like a trip
// R15 - status register shows trip input level and which half-period runs
// R16 - shutdown controller merges all sources and resets the timing unit
// R17 - all timing counts in cycles of the instruction-rate clock
// R18 - one interrupt per sync pulse, a separate one on any shutdown
// R19 - 16-bit timing unit; period, dead, min pulse, sync width, duties from registers
// R20 - per phase a complementary, dead-time-adjusted, centre-aligned pair is built
// R21 - gate stage mixes the chopping signal into the switching outputs
// R22 - period register counts cycles in half a switching period
// R23 - dead time is the 10-bit value times two cycles; zero gives none
// R24 - status bit 3 clear in first half, set in second half
// R25 - sync pulse lasts sync-width plus one cycles; sync width resets to 0x27
// R26 - pulses narrower than the minimum-pulse register are deleted; the code deletes pulses narrower than twice that value in cycles
// R27 - after shutdown, outputs stay off until software clears and trip is high
package tpc_pkg;

   localparam int unsigned TPC_AW = 4;
   localparam int unsigned TPC_DW = 16;
   localparam int unsigned TPC_PHASES = 3;

   // register word addresses
   localparam logic [3:0] TPC_REG_PERIOD = 4'h0;
   localparam logic [3:0] TPC_REG_DEAD = 4'h1;
   localparam logic [3:0] TPC_REG_MINPULSE = 4'h2;
   localparam logic [3:0] TPC_REG_SYNCW = 4'h3;
   localparam logic [3:0] TPC_REG_DUTY_A = 4'h4;
   localparam logic [3:0] TPC_REG_DUTY_B = 4'h5;
   localparam logic [3:0] TPC_REG_DUTY_C = 4'h6;
   localparam logic [3:0] TPC_REG_SEG = 4'h7;
   localparam logic [3:0] TPC_REG_GATE = 4'h8;
   localparam logic [3:0] TPC_REG_MODE = 4'h9;
   localparam logic [3:0] TPC_REG_SWTRIP = 4'ha;
   localparam logic [3:0] TPC_REG_STATUS = 4'hb;
   localparam logic [3:0] TPC_REG_TRIPCLR = 4'hc;

   // reset values
   localparam logic [15:0] TPC_PERIOD_RST = 16'h03e8;
   localparam logic [9:0] TPC_DEAD_RST = 10'h000;
   localparam logic [15:0] TPC_MINPULSE_RST = 16'h0000;
   localparam logic [7:0] TPC_SYNCW_RST = 8'h27;
   localparam logic [15:0] TPC_DUTY_RST = 16'h0000;
   localparam logic [8:0] TPC_SEG_RST = 9'h1f8;
   localparam logic [9:0] TPC_GATE_RST = 10'h000;
   localparam logic [15:0] TPC_MODE_RST = 16'h0000;

   // field positions
   localparam int unsigned TPC_SEG_XOVER_LSB = 0;
   localparam int unsigned TPC_SEG_EN_LSB = 3;
   localparam int unsigned TPC_GATE_HI_BIT = 8;
   localparam int unsigned TPC_GATE_LO_BIT = 9;
   localparam int unsigned TPC_MODE_DOUBLE_BIT = 6;
   localparam int unsigned TPC_STAT_TRIP_BIT = 0;
   localparam int unsigned TPC_STAT_SHUT_BIT = 1;
   localparam int unsigned TPC_STAT_OC_BIT = 2;
   localparam int unsigned TPC_STAT_HALF_BIT = 3;
   localparam int unsigned TPC_CLR_BIT = 0;

   // timing-unit configuration, taken as one word at each update instant
   typedef struct packed {
      logic [15:0] period;
      logic [9:0] dead;
      logic [15:0] min_pulse;
      logic [7:0] sync_width;
      logic [2:0][15:0] duty;
      logic [2:0] xover;
      logic [5:0] out_en;
   } tpc_cfg_t;

endpackage

// *** testbench/tpc_pwm_top_props.sv ***
// checker: port-level properties of the three-phase pwm top
`timescale 1ns/10ps
`default_nettype none

module tpc_chk
   import tpc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [TPC_AW-1:0] addr,
   input wire logic [TPC_DW-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [TPC_DW-1:0] rdata,
   input wire logic trip_in_n,
   input wire logic current_sense_in,
   input wire logic phase_a_high_out,
   input wire logic phase_a_low_out,
   input wire logic phase_b_high_out,
   input wire logic phase_b_low_out,
   input wire logic phase_c_high_out,
   input wire logic phase_c_low_out,
   input wire logic period_sync_pulse,
   input wire logic sync_irq,
   input wire logic shutdown_irq
);
   wire logic [5:0] outs;
   assign outs = {phase_a_high_out, phase_a_low_out, phase_b_high_out, phase_b_low_out,
      phase_c_high_out, phase_c_low_out};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_swtrip_wr;
      wr_stb && addr == TPC_REG_SWTRIP;
   endsequence
   // the synchroniser needs the pin steady for its whole depth
   sequence s_trip_steady;
      trip_in_n == $past(trip_in_n) && trip_in_n == $past(trip_in_n, 2) &&
         trip_in_n == $past(trip_in_n, 3);
   endsequence
   property p_no_overlap;
      !(phase_a_high_out && phase_a_low_out) && !(phase_b_high_out && phase_b_low_out) &&
         !(phase_c_high_out && phase_c_low_out);
   endproperty
   property p_trip_off;
      !trip_in_n |-> outs == 6'h00;
   endproperty
   property p_oc_off;
      current_sense_in |-> outs == 6'h00;
   endproperty
   property p_swtrip;
      s_swtrip_wr |-> ##2 outs == 6'h00;
   endproperty
   property p_shut_irq;
      // a software trip latches with the irq, outputs follow one edge later
      shutdown_irq |=> outs == 6'h00;
   endproperty
   property p_sync_irq;
      sync_irq |-> period_sync_pulse;
   endproperty
   property p_rd_idle;
      !$past(rd_stb) |-> rdata == 16'h0000;
   endproperty
   property p_stat_trip;
      (rd_stb && addr == TPC_REG_STATUS) ##0 s_trip_steady |=>
         rdata[TPC_STAT_TRIP_BIT] == $past(trip_in_n);
   endproperty
   property p_unmapped;
      rd_stb && addr > TPC_REG_TRIPCLR |=> rdata == 16'h0000;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both switches of a leg on");
   a_trip_off: assert property (p_trip_off) else $error("outputs on while trip low");
   a_oc_off: assert property (p_oc_off) else $error("outputs on during over-current");
   a_swtrip: assert property (p_swtrip) else $error("software trip left outputs on");
   a_shut_irq: assert property (p_shut_irq) else $error("shutdown irq with outputs on");
   a_sync_irq: assert property (p_sync_irq) else $error("sync irq without sync pulse");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   a_stat_trip: assert property (p_stat_trip) else $error("status trip level wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // tpc_chk

bind tpc_pwm_top tpc_chk chk_u (.sys_clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
   .trip_in_n, .current_sense_in, .phase_a_high_out, .phase_a_low_out, .phase_b_high_out,
   .phase_b_low_out, .phase_c_high_out, .phase_c_low_out, .period_sync_pulse, .sync_irq,
   .shutdown_irq);
`default_nettype wire

// *** testbench/tpc_inverter_model.sv ***
// partner: inverter legs with an over-current comparator
`timescale 1ns/10ps
`default_nettype none

module tpc_inverter_model (
   input wire logic sys_clk,
   input wire logic [5:0] gate_in,
   input wire logic oc_cmd,
   output logic current_sense_in,
   output var int shoot_cnt
);
   // comparator trips while fault current flows
   assign current_sense_in = oc_cmd;
   initial shoot_cnt = 0;
   // a leg with both switches on shorts the link
   always @(posedge sys_clk) begin
      if ((gate_in[5] & gate_in[4]) | (gate_in[3] & gate_in[2]) | (gate_in[1] & gate_in[0])) begin
         shoot_cnt++;
      end
   end
endmodule // tpc_inverter_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// testbench: register, timing, gate and shutdown checks of the pwm top
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import tpc_pkg::*;
   localparam int P = 20;
   logic sys_clk, resetn, wr_stb, rd_stb, trip_in_n, current_sense_in, oc_cmd;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, v, v2;
   logic pa_h, pa_l, pb_h, pb_l, pc_h, pc_l, sync_p, sync_irq, shut_irq;
   int miscompares = 0, checked = 0, shoot_cnt, hi, lo, s, k, d, dt, mp, irq_n = 0;
   logic [15:0] rst_exp [10] = '{16'h03e8, 0, 0, 16'h0027, 0, 0, 0, 16'h01f8, 0, 0};
   logic [15:0] msk [10] = '{16'hffff, 16'h03ff, 16'hffff, 16'h00ff, 16'hffff, 16'hffff,
      16'hffff, 16'h01ff, 16'h03ff, 16'hffff};
   logic [15:0] segs [5] = '{16'h01f9, 16'h01f0, 16'h01e8, 16'h01f8, 16'h01f8};
   logic [15:0] gates [5] = '{0, 0, 0, 16'h0100, 16'h0200};
   int ehi [5] = '{20, 0, 12, 6, 12};
   int elo [5] = '{12, 20, 0, 20, 10};

   tpc_pwm_top dut_u (.sys_clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .trip_in_n,
      .current_sense_in, .phase_a_high_out(pa_h), .phase_a_low_out(pa_l), .phase_b_high_out(pb_h),
      .phase_b_low_out(pb_l), .phase_c_high_out(pc_h), .phase_c_low_out(pc_l),
      .period_sync_pulse(sync_p), .sync_irq, .shutdown_irq(shut_irq));
   tpc_inverter_model inv_u (.sys_clk, .gate_in({pa_h, pa_l, pb_h, pb_l, pc_h, pc_l}), .oc_cmd,
      .current_sense_in, .shoot_cnt);

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // shutdown interrupt pulses, sampled away from the launching edge
   always @(negedge sys_clk) begin
      irq_n += (shut_irq === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_n(input int got, input int exp);
      checked++;
      if (got != exp) begin
         miscompares++;
         $display("BAD t=%0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] dd);
      @(posedge sys_clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= dd;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] dd);
      @(posedge sys_clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      @(negedge sys_clk);
      dd = rdata;
   endtask
   task automatic wait_sync();
      int n;
      for (n = 0; n < 2100 && sync_irq !== 1'b1; n++) @(negedge sys_clk);
      if (n == 0) @(negedge sys_clk);
      for (n = 0; n < 2100 && sync_irq !== 1'b1; n++) @(negedge sys_clk);
      if (n == 2100) cmp_n(n, 0);
   endtask
   task automatic setup(input int dd, ddt, dmp, input logic [15:0] seg, gate, mode, input int sw);
      wr(TPC_REG_PERIOD, 16'(P));
      wr(TPC_REG_DEAD, 16'(ddt));
      wr(TPC_REG_MINPULSE, 16'(dmp));
      wr(TPC_REG_SYNCW, 16'(sw));
      for (int i = 0; i < 3; i++) wr(TPC_REG_DUTY_A + 4'(i), 16'(dd));
      wr(TPC_REG_SEG, seg);
      wr(TPC_REG_GATE, gate);
      wr(TPC_REG_MODE, mode);
      wait_sync();
      wait_sync();
   endtask
   task automatic measure();
      hi = 0;
      lo = 0;
      repeat (2 * P) begin
         @(negedge sys_clk);
         hi += (pa_h === 1'b1);
         lo += (pa_l === 1'b1);
      end
   endtask
   task automatic sync_check(input int expw, input int exps);
      int n;
      wait_sync();
      for (n = 0; sync_p === 1'b1 && n < 300; n++) @(negedge sys_clk);
      cmp_n(n, expw);
      for (; sync_irq !== 1'b1 && n < 3000; n++) @(negedge sys_clk);
      cmp_n(n, exps);
   endtask
   // high: count >= edge + 2*dead; low: count + 2*dead < edge; narrow pulses deleted
   function automatic int exp_hi(int dd, int ddt, int dmp);
      int e = (dd >= P) ? 0 : P - dd;
      return (P - e - 2 * ddt <= 0 || P - e < 2 * ddt + dmp) ? 0 : 2 * (P - e - 2 * ddt);
   endfunction
   function automatic int exp_lo(int dd, int ddt, int dmp);
      int e = (dd >= P) ? 0 : P - dd;
      return (e - 2 * ddt <= 0 || e < 2 * ddt + dmp) ? 0 : 2 * (e - 2 * ddt);
   endfunction
   task automatic report_and_stop();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(25 * 60000);
      miscompares++;
      $display("BAD t=%0t watchdog expired", $time);
      report_and_stop();
   end
   initial begin
      resetn = 1'b0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      trip_in_n = 1'b1;
      oc_cmd = 1'b0;
      k = $urandom(32'ha32d635f);
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      for (k = 0; k < 16; k++) begin
         if (k == 11) continue;
         rd(4'(k), v);
         cmp_v(v, (k < 10) ? rst_exp[k] : 16'h0000);
      end
      for (k = 0; k < 10; k++) begin
         v2 = 16'($urandom);
         wr(4'(k), v2);
         rd(4'(k), v);
         cmp_v(v, v2 & msk[k]);
      end
      $display("end of register test");
      for (k = 0; k < 2; k++) begin
         setup(8, 1, 0, 16'h01f8, 16'h0000, k ? 16'h0040 : 16'h0000, 3);
         sync_check(4, k ? P : 2 * P);
         if (k == 1) begin
            rd(TPC_REG_STATUS, v);
            wait_sync();
            rd(TPC_REG_STATUS, v2);
            cmp_v(16'(v[TPC_STAT_HALF_BIT] ^ v2[TPC_STAT_HALF_BIT]), 16'h0001);
         end
      end
      $display("end of sync test");
      for (k = 0; k < 8; k++) begin
         d = (k == 0) ? 0 : (k == 1) ? P : $urandom_range(2, 18);
         dt = $urandom_range(0, 2);
         mp = (k == 2) ? 5 : $urandom_range(0, 3);
         if (k == 2) d = 8;
         setup(d, dt, mp, 16'h01f8, 16'h0000, 16'h0000, 3);
         measure();
         cmp_n(hi, exp_hi(d, dt, mp));
         cmp_n(lo, exp_lo(d, dt, mp));
      end
      for (k = 0; k < 5; k++) begin
         setup(8, 1, 0, segs[k], gates[k], 16'h0000, 3);
         measure();
         cmp_n(hi, ehi[k]);
         cmp_n(lo, elo[k]);
      end
      $display("end of waveform test");
      // last segment scenario left low-side chopping on
      wr(TPC_REG_GATE, 16'h0000);
      for (s = 0; s < 3; s++) begin
         for (k = 0; k < 100 && pa_l !== 1'b1; k++) @(negedge sys_clk);
         #2;
         if (s == 0) trip_in_n = 1'b0;
         if (s == 1) oc_cmd = 1'b1;
         #1;
         if (s < 2) cmp_v(16'(pa_l), 16'h0000);
         if (s == 2) wr(TPC_REG_SWTRIP, 16'($urandom));
         repeat (3) @(posedge sys_clk);
         // clear while the source is still active must be refused
         if (s < 2) wr(TPC_REG_TRIPCLR, 16'h0001);
         trip_in_n <= 1'b1;
         oc_cmd <= 1'b0;
         repeat (4) @(posedge sys_clk);
         measure();
         cmp_n(hi + lo, 0);
         rd(TPC_REG_STATUS, v);
         cmp_v(v & 16'h0002, 16'h0002);
         wr(TPC_REG_TRIPCLR, 16'h0001);
         wait_sync();
         wait_sync();
         measure();
         cmp_n(hi, 12);
         cmp_n(lo, 20);
      end
      $display("end of shutdown test");
      cmp_n(shoot_cnt, 0);
      cmp_n(irq_n, 3);
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
